//--- hdl/video_denoise_filter.sv
// Luma denoise datapath: motion history, filters, blend, noise estimate
`timescale 1ns/1ps
module video_denoise_filter #(
  parameter int SUM_W     = denoise_pkg::SUM_W_DEF,
  parameter int CNT_W     = denoise_pkg::CNT_W_DEF,
  parameter bit DIFF_6BIT = 1'b0
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  // Configuration
  input  wire denoise_pkg::cfg_t   cfg_i,
  input  wire logic                frame_start_i,
  // Motion block in
  input  wire logic                blk_valid_i,
  input  wire denoise_pkg::blk_t   blk_curr_i,
  input  wire denoise_pkg::blk_t   blk_prev_i,
  input  wire logic [7:0]          hist_i,
  // Motion history out
  output logic                     hist_valid_o,
  output logic [7:0]               hist_o,
  output logic                     moving_o,
  // Pixel in
  input  wire logic                pix_valid_i,
  input  wire denoise_pkg::win_t   pix_win_i,
  input  wire logic [7:0]          pix_prev_i,
  // Pixel and block estimate out
  output logic                     den_valid_o,
  output logic [7:0]               den_o,
  output logic                     noise_valid_o,
  output logic [7:0]               noise_o,
  // Frame report out
  output logic                     report_valid_o,
  output logic                     report_stream_o,
  output logic [SUM_W-1:0]         report_sum_o,
  output logic [CNT_W-1:0]         report_count_o
);

  // Sum must hold 32,400 blocks of 8-bit values; count the same many blocks
  if (SUM_W < 23 || SUM_W > 32) begin : g_sum_chk
    $error("SUM_W must be within 23..32");
  end
  if (CNT_W < 15 || CNT_W > 32) begin : g_cnt_chk
    $error("CNT_W must be within 15..32");
  end

  typedef struct packed {
    denoise_pkg::cfg_t           cfg;
    logic [7:0]                  hist;
    logic                        moving;
    logic                        hist_valid;
    logic [7:0]                  den;
    logic                        den_valid;
    logic [7:0]                  pix_cnt;
    logic [7:0]                  blk_min;
    logic                        stream;
    logic [7:0]                  noise;
    logic                        noise_valid;
    logic [1:0][SUM_W-1:0]       sum;
    logic [1:0][CNT_W-1:0]       cnt;
    logic [SUM_W-1:0]            rpt_sum;
    logic [CNT_W-1:0]            rpt_cnt;
    logic                        rpt_valid;
    logic                        rpt_stream;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [7:0] win_med;
  logic [7:0] win_min;
  logic [7:0] win_max;

  nine_point_median u_rank (
    .win_i (pix_win_i),
    .med_o (win_med),
    .min_o (win_min),
    .max_o (win_max)
  );

  function automatic logic [7:0] absd(input logic [7:0] a,
                                      input logic [7:0] b);
    absd = (a >= b) ? (a - b) : (b - a);
  endfunction

  always_comb begin
    logic [7:0]         ad;
    logic signed [8:0]  sd;
    logic [11:0]        sad;
    logic [4:0]         mcnt;
    logic signed [12:0] ssum;
    logic [12:0]        smag;
    logic [12:0]        cplx;
    logic [7:0]         hnew;
    logic               mov;
    logic [17:0]        tmix;
    logic [7:0]         tden;
    logic [11:0]        gsum;
    logic [3:0]         gcnt;
    logic [23:0]        sprod;
    logic [7:0]         sden;
    logic [7:0]         td;
    logic [7:0]         gap;
    logic [13:0]        bsum;
    logic [24:0]        bprod;
    logic [9:0]         gtop;
    logic [9:0]         gbot;
    logic [9:0]         hz;
    logic [9:0]         vt;
    logic [7:0]         edge_v;
    logic [11:0]        metric;
    logic [7:0]         dmin;
    logic [7:0]         dmax;
    logic [7:0]         m8;
    logic [7:0]         cur_min;
    logic [7:0]         blk_size;
    logic               cur_stream;
    logic               sel;

    ad = 8'h00; sd = '0; sad = '0; mcnt = '0; ssum = '0; smag = '0;
    cplx = '0; hnew = '0; mov = 1'b0; tmix = '0; tden = '0; gsum = '0;
    gcnt = '0; sprod = '0; sden = '0; td = '0; gap = '0; bsum = '0;
    bprod = '0; gtop = '0; gbot = '0; hz = '0; vt = '0; edge_v = '0;
    metric = '0; dmin = 8'hFF; dmax = 8'h00; m8 = '0; cur_min = '0;
    blk_size = '0; cur_stream = 1'b0; sel = 1'b0;

    st_nxt             = st_r;
    st_nxt.hist_valid  = 1'b0;
    st_nxt.den_valid   = 1'b0;
    st_nxt.noise_valid = 1'b0;
    st_nxt.rpt_valid   = 1'b0;

    // Motion block: statistics and history update
    if (blk_valid_i) begin
      for (int i = 0; i < 16; i++) begin
        ad = absd(blk_curr_i[i], blk_prev_i[i]);
        sd = $signed({1'b0, blk_curr_i[i]}) - $signed({1'b0, blk_prev_i[i]});
        sad = sad + 12'(ad);
        if (ad >= cfg_i.temporal_gap_limit) begin
          mcnt = mcnt + 5'h01;
        end
        ssum = ssum + 13'(sd);
      end
      smag = (ssum < 0) ? 13'(-ssum) : 13'(ssum);
      for (int y = 0; y < 4; y++) begin
        for (int x = 0; x < 3; x++) begin
          cplx = cplx + 13'(absd(blk_curr_i[y*4+x], blk_curr_i[y*4+x+1]));
        end
      end
      for (int y = 0; y < 3; y++) begin
        for (int x = 0; x < 4; x++) begin
          cplx = cplx + 13'(absd(blk_curr_i[y*4+x], blk_curr_i[y*4+x+4]));
        end
      end
      mov = (sad > cfg_i.motion_sad_limit) ||
            (mcnt > cfg_i.motion_count_limit);
      if (mov) begin
        hnew = (hist_i >= denoise_pkg::HIST_MID) ? (hist_i >> 1) : 8'h00;
      end else begin
        // static block growth, capped at full scale
        if (hist_i < denoise_pkg::HIST_MID) begin
          hnew = denoise_pkg::HIST_MID;
        end else if (hist_i < cfg_i.history_ceiling) begin
          hnew = (9'(hist_i) + 9'(cfg_i.history_step) > 9'h0FF) ?
                 8'hFF : hist_i + cfg_i.history_step;
        end else begin
          hnew = hist_i;
        end
        if (smag > cfg_i.signed_diff_limit &&
            cplx < cfg_i.complexity_limit) begin
          hnew = denoise_pkg::HIST_MID;
        end
      end
      // history out and kept for filter
      st_nxt.hist       = hnew;
      st_nxt.moving     = mov;
      st_nxt.hist_valid = 1'b1;
      st_nxt.cfg        = cfg_i;
    end

    // report previous totals, then clear the selected set
    if (frame_start_i) begin
      sel               = cfg_i.stream_selector;
      st_nxt.rpt_sum    = st_r.sum[sel];
      st_nxt.rpt_cnt    = st_r.cnt[sel];
      st_nxt.rpt_stream = sel;
      st_nxt.rpt_valid  = 1'b1;
      st_nxt.sum[sel]   = '0;
      st_nxt.cnt[sel]   = '0;
    end

    // Pixel path uses the history of the last motion block
    if (pix_valid_i) begin
      tmix = 18'(st_r.hist) * 18'(pix_prev_i) +
             (denoise_pkg::TEMP_FULL - 18'(st_r.hist)) * 18'(pix_win_i[4]) +
             denoise_pkg::TEMP_ROUND;
      tden = 8'(tmix >> denoise_pkg::TEMP_SHIFT);
      if (tden >= win_max) begin
        tden = 8'((9'(tden) + 9'(win_max)) >> 1);
      end
      if (tden < win_min) begin
        tden = 8'((9'(tden) + 9'(win_min)) >> 1);
      end

      for (int i = 0; i < 9; i++) begin
        if (i == 4 || absd(pix_win_i[i], pix_win_i[4]) <=
                      st_r.cfg.neighbour_similarity_limit) begin
          gsum = gsum + 12'(pix_win_i[i]);
          gcnt = gcnt + 4'h1;
        end
      end
      sprod = 24'(gsum + 12'(gcnt >> 1)) *
              24'(denoise_pkg::NB_RECIP[gcnt - 4'h1]);
      sden  = 8'(sprod >> denoise_pkg::SP_SHIFT);

      td = absd(pix_win_i[4], pix_prev_i);
      if (DIFF_6BIT && td > denoise_pkg::DIFF6_MAX) begin
        td = denoise_pkg::DIFF6_MAX;
      end
      gap = st_r.cfg.temporal_gap_limit - st_r.cfg.blend_low_limit;
      // hard selection outside the blend band
      if (td >= st_r.cfg.temporal_gap_limit || st_r.moving) begin
        st_nxt.den = sden;
      end else if (td < st_r.cfg.blend_low_limit) begin
        st_nxt.den = tden;
      end else begin
        // distance weighted blend; gap of 1..16 relied upon
        // out-of-range gap picks a wrong table entry; above 64 the 14-bit sum also wraps
        bsum  = 14'(sden) * 14'(td - st_r.cfg.blend_low_limit) +
                14'(tden) * 14'(st_r.cfg.temporal_gap_limit - td) +
                14'(gap >> 1);
        bprod = 25'(bsum) * 25'(denoise_pkg::GAP_RECIP[4'(gap - 8'h01)]);
        st_nxt.den = 8'(bprod >> denoise_pkg::BL_SHIFT);
      end
      st_nxt.den_valid = 1'b1;

      gtop = 10'(pix_win_i[0]) + {pix_win_i[1], 1'b0} + 10'(pix_win_i[2]);
      gbot = 10'(pix_win_i[6]) + {pix_win_i[7], 1'b0} + 10'(pix_win_i[8]);
      hz   = (gtop >= gbot) ? gtop - gbot : gbot - gtop;
      gtop = 10'(pix_win_i[0]) + {pix_win_i[3], 1'b0} + 10'(pix_win_i[6]);
      gbot = 10'(pix_win_i[2]) + {pix_win_i[5], 1'b0} + 10'(pix_win_i[8]);
      vt   = (gtop >= gbot) ? gtop - gbot : gbot - gtop;
      edge_v = 8'((11'(hz) + 11'(vt)) >> denoise_pkg::EDGE_SHIFT);

      for (int i = 0; i < 9; i++) begin
        ad     = absd(pix_win_i[i], win_med);
        metric = metric + 12'(ad);
        if (ad < dmin) begin
          dmin = ad;
        end
        if (ad > dmax) begin
          dmax = ad;
        end
      end
      // Metric saturates so it fits the 8-bit estimate
      m8 = (metric > 12'h0FF) ? 8'hFF : 8'(metric);

      cur_min    = (st_r.pix_cnt == 8'h00) ? denoise_pkg::NOISE_NONE
                                           : st_r.blk_min;
      cur_stream = (st_r.pix_cnt == 8'h00) ? st_r.cfg.stream_selector
                                           : st_r.stream;
      if (edge_v < st_r.cfg.edge_strength_limit &&
          (dmax - dmin) < st_r.cfg.noise_spread_limit &&
          m8 < cur_min) begin
        cur_min = m8;
      end
      st_nxt.blk_min = cur_min;
      st_nxt.stream  = cur_stream;

      // block length follows the deinterlace mode
      blk_size = st_r.cfg.deinterlacing_function ? denoise_pkg::BLK_PIX_DI
                                                 : denoise_pkg::BLK_PIX_DN;
      if (st_r.pix_cnt == blk_size - 8'h01) begin
        st_nxt.pix_cnt     = 8'h00;
        st_nxt.noise       = cur_min;
        st_nxt.noise_valid = 1'b1;
        // set chosen by the block's stream
        if (cur_min != denoise_pkg::NOISE_NONE) begin
          st_nxt.sum[cur_stream] = st_nxt.sum[cur_stream] +
                                   SUM_W'(cur_min);
          st_nxt.cnt[cur_stream] = st_nxt.cnt[cur_stream] +
                                   CNT_W'(1);
        end
      end else begin
        st_nxt.pix_cnt = st_r.pix_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r         <= '0;
      st_r.cfg     <= denoise_pkg::CFG_RESET;
      st_r.hist    <= denoise_pkg::HIST_RESET;
      st_r.blk_min <= denoise_pkg::NOISE_NONE;
      st_r.noise   <= denoise_pkg::NOISE_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hist_valid_o    = st_r.hist_valid;
  assign hist_o          = st_r.hist;
  assign moving_o        = st_r.moving;
  assign den_valid_o     = st_r.den_valid;
  assign den_o           = st_r.den;
  assign noise_valid_o   = st_r.noise_valid;
  assign noise_o         = st_r.noise;
  assign report_valid_o  = st_r.rpt_valid;
  assign report_stream_o = st_r.rpt_stream;
  assign report_sum_o    = st_r.rpt_sum;
  assign report_count_o  = st_r.rpt_cnt;

endmodule

//--- hdl/denoise_pkg.sv
// Constants, configuration and carrier types for the luma denoise datapath
package denoise_pkg;

  // Field widths
  localparam int PIX_W      = 8;
  localparam int SUM_W_DEF  = 23;
  localparam int CNT_W_DEF  = 16;

  // Motion history figures
  localparam logic [7:0] HIST_MID      = 8'h80;
  localparam logic [7:0] HIST_STEP_DEF = 8'h08;
  localparam logic [7:0] HIST_CEIL_DEF = 8'hF0;
  localparam logic [7:0] HIST_RESET    = 8'h00;

  // Noise estimate marker for "no qualifying pixel"
  localparam logic [7:0] NOISE_NONE    = 8'hFF;

  // Output block sizes in pixels (16x4 and 16x8)
  localparam logic [7:0] BLK_PIX_DI    = 8'h40;
  localparam logic [7:0] BLK_PIX_DN    = 8'h80;

  // Arithmetic shifts and rounding
  localparam int TEMP_SHIFT  = 8;
  localparam int SP_SHIFT    = 11;
  localparam int BL_SHIFT    = 10;
  localparam int EDGE_SHIFT  = 3;
  localparam logic [17:0] TEMP_ROUND = 18'h00080;
  localparam logic [17:0] TEMP_FULL  = 18'h00100;
  localparam logic [7:0]  DIFF6_MAX  = 8'h3F;

  // Reciprocal of neighbour count 1..9, scaled by 2048
  localparam logic [11:0] NB_RECIP [9] = '{
    12'h800, 12'h400, 12'h2AA, 12'h200, 12'h199,
    12'h155, 12'h124, 12'h100, 12'h0E3};

  // Reciprocal of threshold gap 1..16, scaled by 1024
  localparam logic [10:0] GAP_RECIP [16] = '{
    11'h400, 11'h200, 11'h155, 11'h100, 11'h0CD, 11'h0AB,
    11'h092, 11'h080, 11'h072, 11'h066, 11'h05D, 11'h055,
    11'h04F, 11'h049, 11'h044, 11'h040};

  // Static configuration, sampled at motion block start
  typedef struct packed {
    logic [7:0]  temporal_gap_limit;
    logic [7:0]  blend_low_limit;
    logic [11:0] motion_sad_limit;
    logic [4:0]  motion_count_limit;
    logic [12:0] signed_diff_limit;
    logic [12:0] complexity_limit;
    logic [7:0]  history_ceiling;
    logic [7:0]  history_step;
    logic [7:0]  neighbour_similarity_limit;
    logic [7:0]  edge_strength_limit;
    logic [7:0]  noise_spread_limit;
    logic        stream_selector;
    logic        deinterlacing_function;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    temporal_gap_limit:         8'h00,
    blend_low_limit:            8'h00,
    motion_sad_limit:           12'h000,
    motion_count_limit:         5'h00,
    signed_diff_limit:          13'h0000,
    complexity_limit:           13'h0000,
    history_ceiling:            HIST_CEIL_DEF,
    history_step:               HIST_STEP_DEF,
    neighbour_similarity_limit: 8'h00,
    edge_strength_limit:        8'h00,
    noise_spread_limit:         8'h00,
    stream_selector:            1'b0,
    deinterlacing_function:     1'b0};

  // 3x3 window, row major, index 4 is the centre
  typedef logic [8:0][7:0]  win_t;
  // 4x4 block, row major
  typedef logic [15:0][7:0] blk_t;

endpackage

//--- hdl/nine_point_median.sv
// Rank statistics of a 3x3 luma window: median, minimum, maximum
`timescale 1ns/1ps
module nine_point_median (
  // Window
  input  wire denoise_pkg::win_t win_i,
  // Statistics
  output logic [7:0]             med_o,
  output logic [7:0]             min_o,
  output logic [7:0]             max_o
);

  // Rank by counting: the median has at most four smaller values and at
  // least five values not larger. Cheaper in depth than a sort network.
  always_comb begin
    logic [3:0] lt;
    logic [3:0] le;
    med_o = win_i[4];
    min_o = win_i[0];
    max_o = win_i[0];
    lt    = 4'h0;
    le    = 4'h0;
    for (int i = 0; i < 9; i++) begin
      lt = 4'h0;
      le = 4'h0;
      for (int j = 0; j < 9; j++) begin
        if (win_i[j] < win_i[i]) begin
          lt = lt + 4'h1;
        end
        if (win_i[j] <= win_i[i]) begin
          le = le + 4'h1;
        end
      end
      if (lt <= 4'h4 && le >= 4'h5) begin
        med_o = win_i[i];
      end
      if (win_i[i] < min_o) begin
        min_o = win_i[i];
      end
      if (win_i[i] > max_o) begin
        max_o = win_i[i];
      end
    end
  end

endmodule

//--- bench/denoise_monitor.sv
// Port-level checks for the luma denoise datapath
`timescale 1ns/1ps
module denoise_monitor (
  // Clock, reset and requests
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire denoise_pkg::cfg_t cfg_i,
  input wire logic              frame_start_i,
  input wire logic              blk_valid_i,
  input wire logic [7:0]        hist_i,
  input wire logic              pix_valid_i,
  // Filter answers
  input wire logic              hist_valid_o,
  input wire logic [7:0]        hist_o,
  input wire logic              moving_o,
  input wire logic              den_valid_o,
  input wire logic              noise_valid_o,
  input wire logic              report_valid_o,
  input wire logic              report_stream_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_hist_answer: assert property (blk_valid_i |=> hist_valid_o)
    else $error("no history after block");
  chk_hist_quiet: assert property (!blk_valid_i |=> !hist_valid_o)
    else $error("history pulse without block");
  chk_hist_held: assert property (
    !hist_valid_o |-> $stable(hist_o) && $stable(moving_o))
    else $error("history changed between blocks");
  chk_moving_halve: assert property (
    hist_valid_o && moving_o |->
      hist_o == ($past(hist_i) >= 8'h80 ? $past(hist_i) >> 1 : 8'h00))
    else $error("moving block history wrong");
  chk_static_floor: assert property (
    hist_valid_o && !moving_o |-> hist_o >= 8'h80)
    else $error("static block history below midpoint");
  chk_pixel_answer: assert property (pix_valid_i |=> den_valid_o)
    else $error("no pixel after request");
  chk_pixel_quiet: assert property (
    !pix_valid_i |=> !den_valid_o && !noise_valid_o)
    else $error("pixel or estimate without request");
  chk_report_stream: assert property (
    frame_start_i |=> report_valid_o &&
      report_stream_o == $past(cfg_i.stream_selector))
    else $error("frame report missing or wrong stream");
  chk_report_quiet: assert property (
    !frame_start_i |=> !report_valid_o)
    else $error("frame report without frame start");

  cover property (hist_valid_o && moving_o);
  cover property (noise_valid_o);
  cover property (report_valid_o && report_stream_o);
endmodule

bind video_denoise_filter denoise_monitor mon_u (
  .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i),
  .frame_start_i(frame_start_i), .blk_valid_i(blk_valid_i),
  .hist_i(hist_i), .pix_valid_i(pix_valid_i),
  .hist_valid_o(hist_valid_o), .hist_o(hist_o), .moving_o(moving_o),
  .den_valid_o(den_valid_o), .noise_valid_o(noise_valid_o),
  .report_valid_o(report_valid_o), .report_stream_o(report_stream_o));

//--- bench/history_memory.sv
// Field-buffer memory and execution-unit sink model
`timescale 1ns/1ps
module history_memory (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // From the filter
  input  wire logic       hist_valid_i,
  input  wire logic [7:0] hist_i,
  input  wire logic       den_valid_i,
  input  wire logic       noise_valid_i,
  // Stored history and return counts
  output logic [7:0]      hist_o,
  output logic [15:0]     den_count_o,
  output logic [15:0]     est_count_o
);
  // One history slot only: the bench revisits the same block position
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hist_o <= 8'h00;
      den_count_o <= 16'h0000;
      est_count_o <= 16'h0000;
    end else begin
      if (hist_valid_i) begin
        hist_o <= hist_i;
      end
      if (den_valid_i) begin
        den_count_o <= den_count_o + 16'h0001;
      end
      if (noise_valid_i) begin
        est_count_o <= est_count_o + 16'h0001;
      end
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the luma denoise datapath
`timescale 1ns/1ps
module tb_top;
  logic              clk_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              frame_start_i, blk_valid_i, pix_valid_i, use_mem;
  logic              hist_valid_o, moving_o, den_valid_o, noise_valid_o;
  logic              report_valid_o, report_stream_o;
  logic [7:0]        hist_tb, hist_mem, pix_prev_i, hist_o, den_o, noise_o;
  logic [22:0]       report_sum_o;
  logic [15:0]       report_count_o, den_seen, est_seen;
  denoise_pkg::cfg_t cfg_i, base;
  denoise_pkg::blk_t blk_curr_i, blk_prev_i;
  denoise_pkg::win_t pix_win_i;
  int                err_count = 0;
  int                checked = 0;

  always #25 clk_i = ~clk_i;

  video_denoise_filter dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg_i),
    .frame_start_i(frame_start_i), .blk_valid_i(blk_valid_i),
    .blk_curr_i(blk_curr_i), .blk_prev_i(blk_prev_i),
    .hist_i(use_mem ? hist_mem : hist_tb), .hist_valid_o(hist_valid_o),
    .hist_o(hist_o), .moving_o(moving_o), .pix_valid_i(pix_valid_i),
    .pix_win_i(pix_win_i), .pix_prev_i(pix_prev_i),
    .den_valid_o(den_valid_o), .den_o(den_o),
    .noise_valid_o(noise_valid_o), .noise_o(noise_o),
    .report_valid_o(report_valid_o), .report_stream_o(report_stream_o),
    .report_sum_o(report_sum_o), .report_count_o(report_count_o));

  history_memory mem_u (
    .clk_i(clk_i), .reset_i(reset_i), .hist_valid_i(hist_valid_o),
    .hist_i(hist_o), .den_valid_i(den_valid_o),
    .noise_valid_i(noise_valid_o), .hist_o(hist_mem),
    .den_count_o(den_seen), .est_count_o(est_seen));

  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  // Expected pixel from the documented filter, blend and clamp steps
  function automatic logic [7:0] ref_den(input denoise_pkg::win_t w,
      input logic [7:0] p, h, input logic mv, input denoise_pkg::cfg_t c);
    int s, n, mx, mn, t, sp, d, g;
    int nq[9] = '{12'h800, 12'h400, 12'h2AA, 12'h200, 12'h199, 12'h155,
                  12'h124, 12'h100, 12'h0E3};
    int gq[16] = '{11'h400, 11'h200, 11'h155, 11'h100, 11'h0CD, 11'h0AB,
                   11'h092, 11'h080, 11'h072, 11'h066, 11'h05D, 11'h055,
                   11'h04F, 11'h049, 11'h044, 11'h040};
    s = 0;
    n = 0;
    mx = 0;
    mn = 255;
    for (int i = 0; i < 9; i++) begin
      if (w[i] > mx) mx = w[i];
      if (w[i] < mn) mn = w[i];
      d = (w[i] > w[4]) ? w[i] - w[4] : w[4] - w[i];
      if (d <= c.neighbour_similarity_limit) begin
        s += w[i];
        n++;
      end
    end
    sp = ((s + n / 2) * nq[n - 1]) >> 11;
    t = (h * p + (256 - h) * w[4] + 128) >> 8;
    if (t >= mx) t = (t + mx) >> 1;
    if (t < mn) t = (t + mn) >> 1;
    d = (w[4] > p) ? w[4] - p : p - w[4];
    g = c.temporal_gap_limit - c.blend_low_limit;
    if (mv || d >= c.temporal_gap_limit) return 8'(sp);
    if (d < c.blend_low_limit) return 8'(t);
    return 8'(((sp * (d - c.blend_low_limit) +
      t * (c.temporal_gap_limit - d) + g / 2) * gq[g - 1]) >> 10);
  endfunction

  task automatic send_block(input denoise_pkg::blk_t c, p,
      input logic [7:0] h, eh, input logic em);
    @(negedge clk_i);
    blk_curr_i = c;
    blk_prev_i = p;
    hist_tb = h;
    blk_valid_i = 1'b1;
    @(negedge clk_i);
    blk_valid_i = 1'b0;
    check(hist_valid_o, 1, "history valid");
    check(hist_o, eh, "history");
    check(moving_o, em, "moving flag");
  endtask

  task automatic t_sad();
    logic [7:0] hv[6] = '{8'hC8, 8'h80, 8'h7F, 8'hC8, 8'hEF, 8'hF0};
    logic [7:0] ev[6] = '{8'h64, 8'h40, 8'h00, 8'hD0, 8'hF7, 8'hF0};
    cfg_i = base;
    for (int i = 0; i < 6; i++) begin
      cfg_i.motion_sad_limit = (i < 3) ? 12'h09F : 12'h0A0;
      send_block({16{8'h14}}, {16{8'h0A}}, hv[i], ev[i], i < 3);
    end
  endtask

  task automatic t_count();
    denoise_pkg::blk_t p;
    p = {16{8'h30}};
    p[0] = 8'h28;
    p[5] = 8'h28;
    p[15] = 8'h28;
    p[9] = 8'h29;
    cfg_i = base;
    cfg_i.motion_sad_limit = 12'hFFF;
    cfg_i.motion_count_limit = 5'h02;
    send_block({16{8'h30}}, p, 8'h64, 8'h00, 1'b1);
    cfg_i.motion_count_limit = 5'h03;
    send_block({16{8'h30}}, p, 8'h64, 8'h80, 1'b0);
  endtask

  task automatic t_force();
    denoise_pkg::blk_t c, pf, pa;
    // Alternate columns: 48 of horizontal complexity, none vertical
    for (int i = 0; i < 16; i++) begin
      c[i] = i[0] ? 8'h05 : 8'h01;
      pf[i] = c[i] - 8'h01;
      pa[i] = i[0] ? 8'h04 : 8'h02;
    end
    cfg_i = base;
    cfg_i.motion_sad_limit = 12'hFFF;
    cfg_i.signed_diff_limit = 13'h000F;
    cfg_i.complexity_limit = 13'h0030;
    send_block(c, pf, 8'hC8, 8'hD0, 1'b0);
    cfg_i.complexity_limit = 13'h0031;
    send_block(c, pf, 8'hC8, 8'h80, 1'b0);
    send_block(c, pa, 8'hC8, 8'hD0, 1'b0);
    cfg_i.signed_diff_limit = 13'h0010;
    send_block(c, pf, 8'hC8, 8'hD0, 1'b0);
  endtask

  // History read back from the memory model steers the next block
  task automatic t_chain();
    cfg_i = base;
    use_mem = 1'b1;
    send_block({16{8'h14}}, {16{8'h14}}, 8'h00, 8'hD8, 1'b0);
    send_block({16{8'h14}}, {16{8'h14}}, 8'h00, 8'hE0, 1'b0);
    use_mem = 1'b0;
  endtask

  task automatic run_pix(input denoise_pkg::cfg_t c,
      input denoise_pkg::win_t w, input logic mv, input logic [7:0] est);
    logic [7:0] pv, eh;
    int n;
    eh = mv ? 8'h64 : 8'hD0;
    n = c.deinterlacing_function ? 64 : 128;
    cfg_i = c;
    send_block({16{8'h14}}, mv ? {16{8'h0A}} : {16{8'h14}}, 8'hC8, eh, mv);
    // Live change must not reach pixels of the latched block
    cfg_i.neighbour_similarity_limit = 8'h00;
    for (int i = 0; i <= n; i++) begin
      @(negedge clk_i);
      if (i > 0) begin
        check(den_valid_o, 1, "pixel valid");
        check(den_o, ref_den(w, pv, eh, mv, c), "pixel");
        check(noise_valid_o, i == n, "block end");
      end
      pv = 8'(i % 32);
      pix_valid_i = (i < n);
      pix_win_i = w;
      pix_prev_i = pv;
    end
    check(noise_o, est, "block estimate");
  endtask

  task automatic frame(input logic s, input logic [22:0] sum,
      input logic [15:0] cnt);
    @(negedge clk_i);
    cfg_i.stream_selector = s;
    frame_start_i = 1'b1;
    @(negedge clk_i);
    frame_start_i = 1'b0;
    check(report_valid_o, 1, "report valid");
    check(report_stream_o, s, "report stream");
    check(report_sum_o, sum, "frame sum");
    check(report_count_o, cnt, "frame count");
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    conclude();
  end

  initial begin
    denoise_pkg::cfg_t c;
    denoise_pkg::win_t wq, we;
    wq = {{4{8'h0A}}, 8'h0C, {4{8'h0A}}};
    we = {{3{8'h1E}}, 8'h0A, 8'h0C, {4{8'h0A}}};
    cfg_i = denoise_pkg::CFG_RESET;
    base = denoise_pkg::CFG_RESET;
    base.temporal_gap_limit = 8'h08;
    // gap of four stays in range
    base.blend_low_limit = 8'h04;
    base.motion_count_limit = 5'h1F;
    base.signed_diff_limit = 13'h1FFF;
    base.neighbour_similarity_limit = 8'h02;
    base.edge_strength_limit = 8'h01;
    base.noise_spread_limit = 8'h03;
    {frame_start_i, blk_valid_i, pix_valid_i, use_mem} = 4'h0;
    {blk_curr_i, blk_prev_i, pix_win_i} = '0;
    {hist_tb, pix_prev_i} = 16'h0000;
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    frame(1'b0, 23'h000000, 16'h0000);
    t_sad();
    t_count();
    t_force();
    t_chain();
    run_pix(base, wq, 1'b0, 8'h02);
    c = base;
    c.edge_strength_limit = 8'h0B;
    c.noise_spread_limit = 8'h15;
    run_pix(c, we, 1'b0, 8'h3E);
    c.edge_strength_limit = 8'h0A;
    run_pix(c, we, 1'b1, 8'hFF);
    c = base;
    c.deinterlacing_function = 1'b1;
    c.stream_selector = 1'b1;
    run_pix(c, wq, 1'b0, 8'h02);
    frame(1'b0, 23'h000040, 16'h0002);
    frame(1'b1, 23'h000002, 16'h0001);
    frame(1'b0, 23'h000000, 16'h0000);
    frame(1'b1, 23'h000000, 16'h0000);
    check(den_seen, 16'h01C0, "pixels returned");
    check(est_seen, 16'h0004, "estimates returned");
    conclude();
  end
endmodule
